//--- sofd_ctrl.sv
// slow oscillator fail detection, safe clock switch and trim control
module sofd_ctrl #(
  parameter int CYCLES_SEL_A_SHIFT = 0 // shortens start-up counts in simulation
) (
  input wire logic CLK_IN, // 25 MHz system clock
  input wire logic RST_IN, // block reset, sync, active high
  input wire logic POR_IN, // power-on reset, sync, active high
  input wire logic EXT_CLK_IN, // external 32k clock pin level
  input wire logic ULP_CLK_IN, // internal oscillator clock level
  input wire logic [5:0] FLASH_TRIM_IN, // factory trim from flash
  input wire logic WDT_REQ_IN, // watchdog clock request
  input sofd_pkg::sofd_run_t RUN_IN, // oscillator run conditions
  input sofd_pkg::sofd_cfg_t CFG_IN, // configuration and strobes
  output sofd_pkg::sofd_status_t STATUS_OUT, // status bits
  output sofd_pkg::sofd_clks_t CLKS_OUT, // clock outputs
  output logic SWITCH_BACK_REQUEST_OUT, // pending switch back
  output logic [1:0] IRQ_FLAG_OUT, // sticky interrupt flags
  output logic [1:0] IRQ_ENABLE_OUT, // interrupt enables
  output logic IRQ_OUT, // shared interrupt line
  output logic FAIL_EVENT_OUT, // one-cycle failure event
  output logic [5:0] ULP_TRIM_OUT, // internal oscillator trim
  output logic CONFIG_WRITE_LOCK_OUT, // internal oscillator lock
  output logic ULP_OSC_ENABLE_OUT // internal oscillator enable
);
  import sofd_pkg::*;

  // start-up length lookup, shortened only by the parameter
  function automatic logic [18:0] cycles_sel_a_len(input logic [2:0] sel);
    logic [18:0] n;
    n = SOFD_CYC_2K;
    unique case (sel)
      SOFD_SU_2K: n = SOFD_CYC_2K;
      SOFD_SU_4K: n = SOFD_CYC_4K;
      SOFD_SU_16K: n = SOFD_CYC_16K;
      SOFD_SU_32K: n = SOFD_CYC_32K;
      SOFD_SU_64K: n = SOFD_CYC_64K;
      SOFD_SU_128K: n = SOFD_CYC_128K;
      SOFD_SU_256K: n = SOFD_CYC_256K;
      default: n = SOFD_CYC_256K;
    endcase
    return n >> CYCLES_SEL_A_SHIFT;
  endfunction

  typedef enum logic [2:0] {
    SU_OFF = 3'h1,
    SU_ULP = 3'h2,
    SU_EXT = 3'h4
  } sofd_su_t;

  logic ext_s, ulp_s;
  logic ext_d1_q, ulp_d1_q;
  logic ext_rise, ext_fall, ulp_rise;
  logic osc_run;
  sofd_su_t su_q;
  logic [18:0] su_cnt_q;
  logic [1:0] tail_cnt_q;
  logic ready_q, ready_d1_q;
  logic safe32_q, safe_d1_q, safe_tick;
  logic [1:0] win_q;
  logic rise_seen_q, fall_seen_q;
  logic detect_on;
  logic fail_q, fail_d1_q, fail_rise;
  logic switched_q, switch_back_request_q;
  logic [3:0] ulp_div_q, safe_div_q, ext_div_q;
  logic ulp1k_q, safe1k_q, ext1k_q;
  logic [1:0] flag_q, en_q, flag_set;
  logic irq_q, event_q;
  logic [5:0] trim_q;
  logic lock_q;
  sofd_clks_t clks_q;

  // both slow clocks come from outside this domain
  sofd_sync #(.W(2)) u_sync (
    .clk_in(CLK_IN),
    .d_in({EXT_CLK_IN, ULP_CLK_IN}),
    .q_out({ext_s, ulp_s})
  );

  // edge detection on synchronised levels only
  always_ff @(posedge CLK_IN) begin
    ext_d1_q <= ext_s;
    ulp_d1_q <= ulp_s;
  end
  assign ext_rise = ext_s & ~ext_d1_q;
  assign ext_fall = ~ext_s & ext_d1_q;
  assign ulp_rise = ulp_s & ~ulp_d1_q;

  // oscillator runs per enable, on-demand and standby
  assign osc_run = RUN_IN.ext_osc_enable &
    ((~RUN_IN.on_demand & (~RUN_IN.standby | RUN_IN.run_standby)) |
     RUN_IN.periph_request);

  // start-up: internal cycles then three external cycles
  // a stop of the oscillator restarts the whole sequence
  always_ff @(posedge CLK_IN) begin
    if (POR_IN || !osc_run) begin
      su_q <= SU_OFF;
      su_cnt_q <= '0;
      tail_cnt_q <= '0;
      ready_q <= 1'b0;
    end else begin
      unique case (su_q)
        SU_OFF: begin
          su_q <= SU_ULP;
          su_cnt_q <= '0;
        end
        SU_ULP: if (ulp_rise) begin
          if (su_cnt_q + 19'h00001 >= cycles_sel_a_len(CFG_IN.cycles_sel_a)) begin
            su_q <= SU_EXT;
            tail_cnt_q <= '0;
          end
          su_cnt_q <= su_cnt_q + 19'h00001;
        end
        SU_EXT: if (ext_rise && !ready_q) begin
          tail_cnt_q <= tail_cnt_q + 2'h1;
          if (tail_cnt_q + 2'h1 == SOFD_EXT_TAIL) begin
            ready_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // safe clock: internal clock, optionally halved
  always_ff @(posedge CLK_IN) begin
    if (POR_IN) begin
      safe32_q <= 1'b0;
      safe_d1_q <= 1'b0;
    end else begin
      safe_d1_q <= safe32_q;
      if (!CFG_IN.safe_clk_prescale) begin
        safe32_q <= ulp_s;
      end else if (ulp_rise) begin
        safe32_q <= ~safe32_q;
      end
    end
  end
  assign safe_tick = safe32_q & ~safe_d1_q;

  // detector active only after start-up and while running
  assign detect_on = CFG_IN.fail_detect_enable & ready_q & osc_run;

  // monitor window of four safe periods
  always_ff @(posedge CLK_IN) begin
    if (POR_IN || !detect_on) begin
      win_q <= '0;
      rise_seen_q <= 1'b0;
      fall_seen_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (safe_tick && win_q == SOFD_WIN_LAST) begin
      // status tracks the latest window, so it clears on recovery
      fail_q <= ~((rise_seen_q | ext_rise) & (fall_seen_q | ext_fall));
      win_q <= '0;
      rise_seen_q <= 1'b0;
      fall_seen_q <= 1'b0;
    end else begin
      if (safe_tick) begin
        win_q <= win_q + 2'h1;
      end
      rise_seen_q <= rise_seen_q | ext_rise;
      fall_seen_q <= fall_seen_q | ext_fall;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (POR_IN) begin
      fail_d1_q <= 1'b0;
      ready_d1_q <= 1'b0;
    end else begin
      fail_d1_q <= fail_q;
      ready_d1_q <= ready_q;
    end
  end
  assign fail_rise = fail_q & ~fail_d1_q;

  // switch to safe clock on failure; oscillator enable untouched
  // switch back completes the cycle after a pending request meets a clear failure status
  always_ff @(posedge CLK_IN) begin
    if (POR_IN) begin
      switched_q <= 1'b0;
      switch_back_request_q <= 1'b0;
    end else if (fail_rise) begin
      switched_q <= 1'b1;
      switch_back_request_q <= switch_back_request_q | CFG_IN.switch_back_request_wr;
    end else if (switch_back_request_q && !fail_q) begin
      switched_q <= 1'b0;
      switch_back_request_q <= 1'b0;
    end else begin
      switch_back_request_q <= switch_back_request_q | CFG_IN.switch_back_request_wr;
    end
  end

  // failure event, held back once already on the safe clock
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || POR_IN) begin
      event_q <= 1'b0;
    end else begin
      event_q <= fail_rise & CFG_IN.fail_event_out_enable &
        ~switched_q;
    end
  end

  // 1k dividers: toggle every sixteen 32k rising edges
  always_ff @(posedge CLK_IN) begin
    if (POR_IN) begin
      ulp_div_q <= '0;
      safe_div_q <= '0;
      ext_div_q <= '0;
      ulp1k_q <= 1'b0;
      safe1k_q <= 1'b0;
      ext1k_q <= 1'b0;
    end else begin
      if (ulp_rise) begin
        ulp_div_q <= ulp_div_q + 4'h1;
        if (ulp_div_q == SOFD_DIV1K_LAST) ulp1k_q <= ~ulp1k_q;
      end
      if (safe_tick) begin
        safe_div_q <= safe_div_q + 4'h1;
        if (safe_div_q == SOFD_DIV1K_LAST) safe1k_q <= ~safe1k_q;
      end
      if (ext_rise && ready_q) begin
        ext_div_q <= ext_div_q + 4'h1;
        if (ext_div_q == SOFD_DIV1K_LAST) ext1k_q <= ~ext1k_q;
      end
    end
  end

  // clock outputs; external masked until ready
  always_ff @(posedge CLK_IN) begin
    if (POR_IN) begin
      clks_q <= '0;
    end else begin
      clks_q.ulp_32k <= ulp_s;
      clks_q.ulp_1k <= ulp1k_q;
      clks_q.wdt_clk <= ulp1k_q & WDT_REQ_IN;
      if (switched_q) begin
        clks_q.ext_32k <= safe32_q;
        clks_q.ext_1k <= safe1k_q;
      end else begin
        clks_q.ext_32k <= ext_s & ready_q;
        clks_q.ext_1k <= ext1k_q & ready_q;
      end
      // source chosen by software beforehand
      case (CFG_IN.rtc_source_control)
        SOFD_RTC_ULP1K: clks_q.rtc_clk <= ulp1k_q;
        SOFD_RTC_ULP32K: clks_q.rtc_clk <= ulp_s;
        SOFD_RTC_EXT1K:
          clks_q.rtc_clk <= switched_q ? safe1k_q : (ext1k_q & ready_q);
        SOFD_RTC_EXT32K:
          clks_q.rtc_clk <= switched_q ? safe32_q : (ext_s & ready_q);
        default: clks_q.rtc_clk <= 1'b0; // reserved codes give no clock
      endcase
    end
  end

  // flags set on rising status; a set beats a same-cycle clear
  assign flag_set = {fail_rise, ready_q & ~ready_d1_q};
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || POR_IN) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~CFG_IN.irq_flag_clear_wr) | flag_set;
    end
  end

  // enables: set strobe wins over clear strobe
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || POR_IN) begin
      en_q <= '0;
    end else begin
      en_q <= (en_q & ~CFG_IN.irq_enable_clear_wr) |
        CFG_IN.irq_enable_set_wr;
    end
  end

  // one shared line while any enabled flag stands
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || POR_IN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flag_q & en_q);
    end
  end

  // trim loads from flash at power-on; writes blocked once locked
  always_ff @(posedge CLK_IN) begin
    if (POR_IN) begin
      trim_q <= FLASH_TRIM_IN;
      lock_q <= 1'b0;
    end else begin
      if (CFG_IN.ulp_trim_wr && !lock_q) begin
        trim_q <= CFG_IN.ulp_trim_wdata;
      end
      if (CFG_IN.config_write_lock_wr) begin
        lock_q <= 1'b1;
      end
    end
  end

  // internal oscillator held off only during power-on
  logic ulp_en_q;
  always_ff @(posedge CLK_IN) begin
    ulp_en_q <= ~POR_IN;
  end

  // outputs straight from flip-flops
  assign STATUS_OUT = '{safe_clk_switched: switched_q,
                        ext_clk_fail: fail_q,
                        ext_osc_ready: ready_q};
  assign CLKS_OUT = clks_q;
  assign SWITCH_BACK_REQUEST_OUT = switch_back_request_q;
  assign IRQ_FLAG_OUT = flag_q;
  assign IRQ_ENABLE_OUT = en_q;
  assign IRQ_OUT = irq_q;
  assign FAIL_EVENT_OUT = event_q;
  assign ULP_TRIM_OUT = trim_q;
  assign CONFIG_WRITE_LOCK_OUT = lock_q;
  assign ULP_OSC_ENABLE_OUT = ulp_en_q;

endmodule

//--- sofd_pkg.sv
// package: constants and carrier types for the slow oscillator fail control
package sofd_pkg;

  // start-up length selections, in internal oscillator cycles
  localparam logic [2:0] SOFD_SU_2K = 3'h0;
  localparam logic [2:0] SOFD_SU_4K = 3'h1;
  localparam logic [2:0] SOFD_SU_16K = 3'h2;
  localparam logic [2:0] SOFD_SU_32K = 3'h3;
  localparam logic [2:0] SOFD_SU_64K = 3'h4;
  localparam logic [2:0] SOFD_SU_128K = 3'h5;
  localparam logic [2:0] SOFD_SU_256K = 3'h6;
  localparam logic [18:0] SOFD_CYC_2K = 19'h00800;
  localparam logic [18:0] SOFD_CYC_4K = 19'h01000;
  localparam logic [18:0] SOFD_CYC_16K = 19'h04000;
  localparam logic [18:0] SOFD_CYC_32K = 19'h08000;
  localparam logic [18:0] SOFD_CYC_64K = 19'h10000;
  localparam logic [18:0] SOFD_CYC_128K = 19'h20000;
  localparam logic [18:0] SOFD_CYC_256K = 19'h40000;
  // external cycles that follow the internal count
  localparam logic [1:0] SOFD_EXT_TAIL = 2'h3;

  // monitor window length in safe clock periods (count 0..3)
  localparam logic [1:0] SOFD_WIN_LAST = 2'h3;
  // 32k to 1k divider: toggle every 16 rising edges
  localparam logic [3:0] SOFD_DIV1K_LAST = 4'hF;

  // source select encodings for the rtc clock
  localparam logic [2:0] SOFD_RTC_ULP1K = 3'h0;
  localparam logic [2:0] SOFD_RTC_ULP32K = 3'h1;
  localparam logic [2:0] SOFD_RTC_EXT1K = 3'h4;
  localparam logic [2:0] SOFD_RTC_EXT32K = 3'h5;

  // interrupt flag positions
  localparam int SOFD_IRQ_RDY = 0;
  localparam int SOFD_IRQ_FAIL = 1;

  localparam logic [5:0] SOFD_TRIM_RST = 6'h00;

  // software configuration and strobes
  typedef struct packed {
    logic fail_detect_enable;
    logic fail_event_out_enable;
    logic safe_clk_prescale;
    logic switch_back_request_wr;
    logic [2:0] cycles_sel_a;
    logic [2:0] rtc_source_control;
    logic [1:0] irq_enable_set_wr;
    logic [1:0] irq_enable_clear_wr;
    logic [1:0] irq_flag_clear_wr;
    logic ulp_trim_wr;
    logic [5:0] ulp_trim_wdata;
    logic config_write_lock_wr;
  } sofd_cfg_t;

  // oscillator run conditions
  typedef struct packed {
    logic ext_osc_enable;
    logic on_demand;
    logic run_standby;
    logic standby;
    logic periph_request;
  } sofd_run_t;

  // status readback
  typedef struct packed {
    logic safe_clk_switched;
    logic ext_clk_fail;
    logic ext_osc_ready;
  } sofd_status_t;

  // clock outputs
  typedef struct packed {
    logic ext_32k;
    logic ext_1k;
    logic ulp_32k;
    logic ulp_1k;
    logic wdt_clk;
    logic rtc_clk;
  } sofd_clks_t;

endpackage

//--- sofd_sync.sv
// two flip-flop synchroniser for a vector of pin levels
module sofd_sync #(
  parameter int W = 2
) (
  input wire logic clk_in, // system clock
  input wire logic [W-1:0] d_in, // asynchronous levels
  output logic [W-1:0] q_out // synchronised levels
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // one chain per bit; the first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_in) begin
      meta_q[i] <= d_in[i];
      sync_q[i] <= meta_q[i];
    end
  end

  assign q_out = sync_q;
endmodule

//--- sofd_ctrl_chk.sv
// concurrent checks on the ports of the slow oscillator fail control
module sofd_ctrl_chk #(
  parameter int CYCLES_SEL_A_SHIFT = 0 // start-up shortening, kept for the bind
) (
  input wire logic CLK_IN, // system clock
  input wire logic RST_IN, // block reset
  input wire logic POR_IN, // power-on reset
  input sofd_pkg::sofd_cfg_t CFG_IN, // configuration and strobes
  input sofd_pkg::sofd_status_t STATUS_OUT, // status bits
  input sofd_pkg::sofd_clks_t CLKS_OUT, // clock outputs
  input wire logic SWITCH_BACK_REQUEST_OUT, // pending switch back
  input wire logic [1:0] IRQ_FLAG_OUT, // sticky flags
  input wire logic [1:0] IRQ_ENABLE_OUT, // enables
  input wire logic IRQ_OUT, // shared line
  input wire logic FAIL_EVENT_OUT, // failure event
  input wire logic [5:0] ULP_TRIM_OUT, // trim
  input wire logic CONFIG_WRITE_LOCK_OUT, // trim lock
  input wire logic ULP_OSC_ENABLE_OUT // internal osc enable
);
  timeunit 1ns;
  timeprecision 1ps;
  import sofd_pkg::*;
  logic irq_cause;
  // flag and enable pair that should drive the line a cycle later
  assign irq_cause = |(IRQ_FLAG_OUT & IRQ_ENABLE_OUT);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (POR_IN || RST_IN);
  // a reset edge clears the line whatever flags stood before it
  chk_irq_line: assert property (
    IRQ_OUT == ($past(irq_cause) && !$past(POR_IN || RST_IN)))
    else $error("irq line wrong");
  chk_fail_flag: assert property (
    $rose(STATUS_OUT.ext_clk_fail) |-> ##[0:1] IRQ_FLAG_OUT[SOFD_IRQ_FAIL])
    else $error("fail flag not set");
  chk_ready_flag: assert property (
    $rose(STATUS_OUT.ext_osc_ready) |-> ##[0:1] IRQ_FLAG_OUT[SOFD_IRQ_RDY])
    else $error("ready flag not set");
  chk_switch_on: assert property (
    $rose(STATUS_OUT.ext_clk_fail) |-> ##[0:1] STATUS_OUT.safe_clk_switched)
    else $error("no switch on failure");
  chk_event_pulse: assert property (
    FAIL_EVENT_OUT |=> !FAIL_EVENT_OUT) else $error("event too long");
  chk_event_cause: assert property (
    FAIL_EVENT_OUT |-> STATUS_OUT.ext_clk_fail &&
      !$past(STATUS_OUT.safe_clk_switched)) else $error("stray event");
  chk_trim_write: assert property (
    CFG_IN.ulp_trim_wr && !CONFIG_WRITE_LOCK_OUT |=>
      ULP_TRIM_OUT == $past(CFG_IN.ulp_trim_wdata)) else $error("trim lost");
  chk_trim_lock: assert property (
    CONFIG_WRITE_LOCK_OUT |=> CONFIG_WRITE_LOCK_OUT && $stable(ULP_TRIM_OUT))
    else $error("locked trim changed");
  chk_back_done: assert property (
    SWITCH_BACK_REQUEST_OUT && !STATUS_OUT.ext_clk_fail &&
      !CFG_IN.switch_back_request_wr |=> !SWITCH_BACK_REQUEST_OUT &&
      !STATUS_OUT.safe_clk_switched) else $error("switch back stuck");
  chk_ulp_on: assert property (
    !$past(POR_IN) && !$past(POR_IN, 2) |-> ULP_OSC_ENABLE_OUT)
    else $error("internal osc off");
  chk_mask_early: assert property (
    !STATUS_OUT.ext_osc_ready && !$past(STATUS_OUT.ext_osc_ready) &&
      !STATUS_OUT.safe_clk_switched && !$past(STATUS_OUT.safe_clk_switched)
      |-> !CLKS_OUT.ext_32k) else $error("clock not masked");
  // main scenarios reached
  cov_fail: cover property ($rose(STATUS_OUT.ext_clk_fail));
  cov_event: cover property (FAIL_EVENT_OUT);
  cov_back: cover property ($fell(SWITCH_BACK_REQUEST_OUT));
endmodule
bind sofd_ctrl sofd_ctrl_chk #(.CYCLES_SEL_A_SHIFT(CYCLES_SEL_A_SHIFT)) sofd_ctrl_chk_i (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .POR_IN(POR_IN), .CFG_IN(CFG_IN),
  .STATUS_OUT(STATUS_OUT), .CLKS_OUT(CLKS_OUT), .IRQ_OUT(IRQ_OUT),
  .SWITCH_BACK_REQUEST_OUT(SWITCH_BACK_REQUEST_OUT),
  .IRQ_FLAG_OUT(IRQ_FLAG_OUT), .IRQ_ENABLE_OUT(IRQ_ENABLE_OUT),
  .FAIL_EVENT_OUT(FAIL_EVENT_OUT), .ULP_TRIM_OUT(ULP_TRIM_OUT),
  .CONFIG_WRITE_LOCK_OUT(CONFIG_WRITE_LOCK_OUT),
  .ULP_OSC_ENABLE_OUT(ULP_OSC_ENABLE_OUT));

//--- sofd_xtal_model.sv
// behavioural slow clock source: crystal or internal oscillator
module sofd_xtal_model (
  input wire logic clk_in, // system clock
  input wire logic run_in, // oscillate while high
  input wire logic [7:0] half_in, // half period minus one, in system clocks
  output logic xtal_out // level at the pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00;
  logic lvl_q = 1'b0;
  assign xtal_out = lvl_q;
  // a dead crystal freezes its level, the case the detector must catch
  always @(posedge clk_in) begin
    if (!run_in || cnt_q >= half_in) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
    if (run_in && cnt_q >= half_in) begin
      lvl_q <= ~lvl_q;
    end
  end
endmodule

//--- sofd_ctrl_test.sv
// self-checking bench for the slow oscillator fail control
module sofd_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sofd_pkg::*;
  localparam int SH = 8; // start-up shortening
  logic clk_in = 0, rst_in = 1, por_in = 1, wdt_req_in = 0, x_run = 1;
  logic ext_clk, ulp_clk, sbr, irq, evt, lock, ulp_en;
  logic [7:0] x_half = 8'h0C;
  logic [5:0] flash_trim = 6'h00, trim;
  logic [1:0] flg, ien;
  sofd_run_t run = '0;
  sofd_cfg_t cfg = '0;
  sofd_status_t st;
  sofd_clks_t ck;
  int num_errors = 0, n_tests = 0, n_evt = 0, cyc = 0, c, n;
  int r [6];
  int ri [4] = '{2, 3, 4, 5};
  logic [2:0] rc [4] = '{SOFD_RTC_ULP1K, SOFD_RTC_ULP32K, SOFD_RTC_EXT1K,
    SOFD_RTC_EXT32K};
  logic [18:0] su_tab [7] = '{SOFD_CYC_2K, SOFD_CYC_4K, SOFD_CYC_16K,
    SOFD_CYC_32K, SOFD_CYC_64K, SOFD_CYC_128K, SOFD_CYC_256K};
  sofd_xtal_model xtal_i (.clk_in(clk_in), .run_in(x_run), .half_in(x_half),
    .xtal_out(ext_clk));
  // internal oscillator: period of 16 system clocks
  sofd_xtal_model ulp_i (.clk_in(clk_in), .run_in(1'b1), .half_in(8'h07),
    .xtal_out(ulp_clk));
  sofd_ctrl #(.CYCLES_SEL_A_SHIFT(SH)) sofd_ctrl_i (.CLK_IN(clk_in),
    .RST_IN(rst_in), .POR_IN(por_in), .EXT_CLK_IN(ext_clk),
    .ULP_CLK_IN(ulp_clk), .FLASH_TRIM_IN(flash_trim),
    .WDT_REQ_IN(wdt_req_in), .RUN_IN(run), .CFG_IN(cfg), .STATUS_OUT(st),
    .CLKS_OUT(ck), .SWITCH_BACK_REQUEST_OUT(sbr), .IRQ_FLAG_OUT(flg),
    .IRQ_ENABLE_OUT(ien), .IRQ_OUT(irq), .FAIL_EVENT_OUT(evt),
    .ULP_TRIM_OUT(trim), .CONFIG_WRITE_LOCK_OUT(lock),
    .ULP_OSC_ENABLE_OUT(ulp_en));
  initial forever #20 clk_in = ~clk_in;
  // event pulse count and a cap on the run length
  always @(posedge clk_in) begin
    n_evt <= n_evt + int'(evt === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_in);
    #2;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait for one status bit, bounded
  task automatic wait_st(input int i, input logic v, output int k);
    k = 0;
    while (st[i] !== v && k < 40000) begin
      step(1);
      k++;
    end
  endtask
  // rising edges of each clock output over k cycles
  task automatic rises(input int k);
    sofd_clks_t p;
    r = '{default: 0};
    p = ck;
    repeat (k) begin
      step(1);
      for (int b = 0; b < 6; b++) r[b] += int'(ck[b] === 1'b1 && !p[b]);
      p = ck;
    end
  endtask
  function automatic logic near(input int a, input int b);
    return a + 1 >= b && a <= b + 1;
  endfunction
  initial begin
    void'($urandom(32'h3247));
    flash_trim = 6'($urandom());
    step(8);
    por_in = 0;
    rst_in = 0;
    step(2);
    check(trim, flash_trim);
    check(ulp_en, 1);
    check({st, flg, ien, sbr, lock}, 0);
    // back-to-back trim writes, the second one after the lock
    c = $urandom_range(63);
    cfg.ulp_trim_wdata = 6'(c);
    cfg.ulp_trim_wr = 1;
    cfg.config_write_lock_wr = 1;
    step(1);
    cfg.config_write_lock_wr = 0;
    cfg.ulp_trim_wdata = ~6'(c);
    step(1);
    cfg.ulp_trim_wr = 0;
    step(1);
    check(trim, 6'(c));
    check(lock, 1);
    // every start-up length, enable to ready
    for (int s = 0; s < 7; s++) begin
      cfg.cycles_sel_a = 3'(s);
      run.ext_osc_enable = 1;
      wait_st(0, 1, c);
      n = int'(su_tab[s] >> SH) * 16;
      check(c >= n - 16 && c <= n + 100, 1);
      run.ext_osc_enable = (s == 6);
      step(2);
    end
    cfg.irq_enable_set_wr = 2'h3;
    step(1);
    cfg.irq_enable_set_wr = 2'h0;
    step(1);
    check({flg, ien, irq}, 5'h0F);
    cfg.irq_flag_clear_wr = 2'h1;
    step(1);
    cfg.irq_flag_clear_wr = 2'h0;
    step(1);
    check({flg, irq}, 0);
    cfg.irq_enable_clear_wr = 2'h1;
    step(1);
    cfg.irq_enable_clear_wr = 2'h0;
    step(1);
    check(ien, 2'h2);
    // external period under three safe periods: the first window is partial
    x_half = 8'($urandom_range(4, 22));
    cfg.fail_event_out_enable = 1;
    cfg.fail_detect_enable = 1; // safe clock already runs
    step(300);
    check(st, 3'h1);
    x_run = 0;
    wait_st(1, 1, c);
    check(c <= 150, 1);
    step(2);
    check({st, flg[1], irq}, 5'h1F);
    check(n_evt, 1);
    rises(512);
    check(near(r[5], r[3]), 1);
    x_run = 1;
    wait_st(1, 0, c);
    check(c <= 150 && st[2], 1);
    cfg.safe_clk_prescale = 1;
    rises(1024);
    check(near(r[5], 32), 1);
    x_run = 0;
    wait_st(1, 1, c);
    step(2);
    check(n_evt, 1);
    cfg.switch_back_request_wr = 1;
    step(1);
    cfg.switch_back_request_wr = 0;
    step(3);
    check({sbr, st[2]}, 2'h3);
    x_run = 1;
    wait_st(2, 0, c);
    check({c <= 400, sbr}, 2'h2);
    cfg.fail_event_out_enable = 0;
    x_run = 0;
    wait_st(1, 1, c);
    step(2);
    check(n_evt, 1);
    rst_in = 1;
    step(1);
    rst_in = 0;
    step(2);
    check({flg, ien, irq, lock, st[1]}, 7'h03);
    run.on_demand = 1;
    run.standby = 1;
    step(3);
    check(st[1:0], 0);
    run.periph_request = 1;
    step(400);
    check(st[1:0], 0);
    foreach (rc[j]) begin
      cfg.rtc_source_control = rc[j];
      wdt_req_in = j[0];
      rises(1100);
      check(near(r[0], r[ri[j]]), 1);
      check(r[1] > 0, j[0]);
    end
    // reserved source code gives no rtc clock
    cfg.rtc_source_control = 3'h2;
    rises(100);
    check(r[0], 0);
    por_in = 1;
    step(1);
    por_in = 0;
    step(2);
    check({lock, trim}, {1'b0, flash_trim});
    summarize();
  end
endmodule
